// ==== src/sipo_pkg.sv ====
// Constants for the serial-in, parallel-out output latch
// How it works
// - Each parallel output drives high, drives low, or floats.
// - With the output enable high all eight outputs float, with it low they drive the stored byte.
// - While the clear input is low the shift stages are held at zero whatever the clocks do.
// - A rising shift clock with clear high moves the serial bit into stage 0 and every stage up one.
// - A rising storage clock with clear high copies all eight shift stages into the storage register.
// - When both clocks rise together the storage register takes the shift stages from before the shift.
// - There is no start-up reset of the storage register, its contents are undefined; the shift stages are zeroed while RST holds the synchronised clear low.
package sipo_pkg;
    localparam int WIDTH = 8;
    localparam int LAST_STAGE = 7;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
endpackage : sipo_pkg

// ==== src/sipo_fifo.sv ====
// Small valid/ready FIFO for shifted serial bits
`timescale 1ns/1ps
module sipo_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : sipo_fifo

// ==== src/sipo_latch.sv ====
// Serial-in, parallel-out latch with three-state outputs, sampled on MCLK
`timescale 1ns/1ps
module sipo_latch (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SERIAL_DATA_IN,
    input wire logic SHIFT_CLOCK,
    input wire logic SHIFT_CLEAR_N,
    input wire logic STORE_CLOCK,
    input wire logic OUT_ENABLE_N,
    output logic [7:0] PARALLEL_OUT,
    output logic [7:0] PARALLEL_OE,
    output logic CASCADE_SERIAL_OUT,
    output logic SHIFT_STALL
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic sclk_prev_q;
    logic rclk_prev_q;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
        end else begin
            meta_q <= {OUT_ENABLE_N, STORE_CLOCK, SHIFT_CLEAR_N, SHIFT_CLOCK, SERIAL_DATA_IN};
            sync_q <= meta_q;
        end
    end

    logic ser_s;
    logic sclk_s;
    logic clr_n_s;
    logic rclk_s;
    logic oe_n_s;
    assign ser_s = sync_q[0];
    assign sclk_s = sync_q[1];
    assign clr_n_s = sync_q[2];
    assign rclk_s = sync_q[3];
    assign oe_n_s = sync_q[4];

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            rclk_prev_q <= rclk_s;
        end
    end

    logic sclk_rise;
    logic rclk_rise;
    assign sclk_rise = sclk_s && !sclk_prev_q;
    assign rclk_rise = rclk_s && !rclk_prev_q;

    // ------------------------------------------------------------
    // Serial bit buffer
    // ------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_data;
    logic fifo_push;
    logic fifo_pop;
    logic shift_go;
    logic store_now;
    logic rclk_pend_q;
    logic [4:0] occ_q;
    logic [4:0] newer_q;

    assign fifo_push = sclk_rise && clr_n_s && fifo_in_ready;
    // Clear flushes queued bits so none can land after it
    assign fifo_pop = fifo_out_valid && (shift_go || !clr_n_s);

    // Each shift edge with clear high queues its sampled bit while the buffer has room; the store edge waits for earlier bits to drain
    sipo_fifo #(
        .WIDTH(1),
        .DEPTH(sipo_pkg::FIFO_DEPTH),
        .AW(sipo_pkg::FIFO_AW)
    ) u_fifo (
        .clk(MCLK),
        .rst(RST),
        .in_valid(sclk_rise && clr_n_s),
        .in_ready(fifo_in_ready),
        .in_data(ser_s),
        .out_valid(fifo_out_valid),
        .out_ready(shift_go || !clr_n_s),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Shift and storage registers
    // ------------------------------------------------------------
    logic [7:0] shift_q;
    logic [7:0] store_q;

    // A store waits only for shifts queued before it, then copies before later ones
    assign store_now = rclk_pend_q && (occ_q == newer_q);
    assign shift_go = fifo_out_valid && clr_n_s && !store_now;

    // Local count of queued bits
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            occ_q <= 5'h00;
        end else begin
            occ_q <= occ_q + {4'h0, fifo_push} - {4'h0, fifo_pop};
        end
    end

    // Bits queued at or after the pending store edge
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            newer_q <= 5'h00;
        end else if (!clr_n_s || store_now) begin
            newer_q <= 5'h00;
        end else if (rclk_rise && !rclk_pend_q) begin
            newer_q <= {4'h0, fifo_push};
        end else if (rclk_pend_q) begin
            newer_q <= newer_q + {4'h0, fifo_push};
        end
    end

    always_ff @(posedge MCLK) begin
        if (!clr_n_s) begin
            shift_q <= 8'h00;
        end else if (shift_go) begin
            shift_q <= {shift_q[6:0], fifo_out_data};
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rclk_pend_q <= 1'b0;
        end else if (!clr_n_s) begin
            rclk_pend_q <= 1'b0;
        end else if (rclk_rise) begin
            rclk_pend_q <= 1'b1;
        end else if (store_now) begin
            rclk_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (store_now && clr_n_s) begin
            store_q <= shift_q;
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PARALLEL_OE <= 8'h00;
        end else begin
            PARALLEL_OE <= {8{!oe_n_s}};
        end
    end

    always_ff @(posedge MCLK) begin
        PARALLEL_OUT <= store_q;
        CASCADE_SERIAL_OUT <= shift_q[sipo_pkg::LAST_STAGE];
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SHIFT_STALL <= 1'b0;
        end else begin
            SHIFT_STALL <= !fifo_in_ready;
        end
    end
endmodule : sipo_latch

// ==== testbench/sipo_gpio_model.sv ====
// GPIO-side pin driver for the shift latch
`timescale 1ns/1ps
module sipo_gpio_model (
    input wire logic mclk,
    output logic serial_data_in,
    output logic shclk,
    output logic clr_n,
    output logic stclk,
    output logic oe_n
);
    initial {serial_data_in, shclk, stclk, clr_n, oe_n} = 5'h03;
    task automatic pulse(input logic sh, input logic st, input logic d);
        serial_data_in <= d;
        repeat (4) @(posedge mclk);
        shclk <= sh;
        stclk <= st;
        repeat (4) @(posedge mclk);
        {shclk, stclk} <= 2'h0;
        serial_data_in <= ~d;
        @(posedge mclk);
    endtask : pulse
endmodule : sipo_gpio_model

// ==== testbench/sipo_latch_monitor.sv ====
// Pin-level checks on the shift latch
`timescale 1ns/1ps
module sipo_latch_monitor (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SHIFT_CLOCK,
    input wire logic SHIFT_CLEAR_N,
    input wire logic STORE_CLOCK,
    input wire logic OUT_ENABLE_N,
    input wire logic [7:0] PARALLEL_OUT,
    input wire logic [7:0] PARALLEL_OE,
    input wire logic CASCADE_SERIAL_OUT
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    // Parallel outputs are undefined until the first store; RST already clears the shift stages
    logic stored_q;
    logic cleared_q;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            stored_q <= 1'b0;
            cleared_q <= 1'b0;
        end else begin
            if (STORE_CLOCK && SHIFT_CLEAR_N) begin
                stored_q <= 1'b1;
            end
            if (!SHIFT_CLEAR_N) begin
                cleared_q <= 1'b1;
            end
        end
    end
    a_oe_uniform: assert property (PARALLEL_OE == 8'h00 || PARALLEL_OE == 8'hff)
        else $error("enables split");
    a_oe_on: assert property ($fell(OUT_ENABLE_N) |-> ##[1:4] PARALLEL_OE == 8'hff)
        else $error("enable late");
    a_oe_off: assert property ($rose(OUT_ENABLE_N) |-> ##[1:4] PARALLEL_OE == 8'h00)
        else $error("disable late");
    a_oe_idle: assert property ($stable(OUT_ENABLE_N)[*4] |-> PARALLEL_OE == {8{~OUT_ENABLE_N}})
        else $error("enable wrong");
    a_clear_zero: assert property ((!SHIFT_CLEAR_N)[*8] |-> !CASCADE_SERIAL_OUT)
        else $error("clear missed");
    a_clear_keeps: assert property ((!SHIFT_CLEAR_N)[*8] ##0 stored_q |=> $stable(PARALLEL_OUT))
        else $error("store under clear");
    a_store_idle: assert property ((!STORE_CLOCK)[*8] ##0 stored_q |=> $stable(PARALLEL_OUT))
        else $error("store uncaused");
    a_shift_idle: assert property ((SHIFT_CLEAR_N && !SHIFT_CLOCK && cleared_q)[*8]
        |=> $stable(CASCADE_SERIAL_OUT))
        else $error("cascade uncaused");
endmodule : sipo_latch_monitor
bind sipo_latch sipo_latch_monitor u_mon (.MCLK(MCLK), .RST(RST), .SHIFT_CLOCK(SHIFT_CLOCK),
    .SHIFT_CLEAR_N(SHIFT_CLEAR_N), .STORE_CLOCK(STORE_CLOCK), .OUT_ENABLE_N(OUT_ENABLE_N),
    .PARALLEL_OUT(PARALLEL_OUT), .PARALLEL_OE(PARALLEL_OE),
    .CASCADE_SERIAL_OUT(CASCADE_SERIAL_OUT));

// ==== testbench/tb_sipo_latch.sv ====
// Self-checking bench for the shift latch
`timescale 1ns/1ps
module tb_sipo_latch;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic serial_data_in, shclk, clr_n, stclk, oe_n, casc;
    logic [7:0] pout;
    logic [7:0] poe;
    int err_count = 0;
    int samples_checked = 0;
    localparam logic [7:0] PAT = 8'ha5;
    initial forever #50 mclk = ~mclk;
    sipo_gpio_model u_gpio (.mclk(mclk), .serial_data_in(serial_data_in), .shclk(shclk), .clr_n(clr_n),
        .stclk(stclk), .oe_n(oe_n));
    sipo_latch DUT (.MCLK(mclk), .RST(rst), .SERIAL_DATA_IN(serial_data_in), .SHIFT_CLOCK(shclk),
        .SHIFT_CLEAR_N(clr_n), .STORE_CLOCK(stclk), .OUT_ENABLE_N(oe_n), .PARALLEL_OUT(pout),
        .PARALLEL_OE(poe), .CASCADE_SERIAL_OUT(casc), .SHIFT_STALL());
    task automatic chk(input string what, input logic [7:0] exp);
        logic [7:0] got;
        repeat (6) @(posedge mclk);
        if (what == "pout") begin
            got = pout;
        end else if (what == "poe") begin
            got = poe;
        end else begin
            got = {7'h0, casc};
        end
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic sc_init;
        u_gpio.clr_n <= 1'b0;
        u_gpio.pulse(1'b1, 1'b0, 1'b1);
        chk("cascade", 8'h00);
        u_gpio.clr_n <= 1'b1;
        u_gpio.pulse(1'b0, 1'b1, 1'b0);
        chk("pout", 8'h00);
    endtask : sc_init
    task automatic sc_byte;
        for (int i = 7; i >= 0; i--) begin
            u_gpio.pulse(1'b1, 1'b0, PAT[i]);
        end
        chk("cascade", 8'h01);
        chk("pout", 8'h00);
        u_gpio.pulse(1'b0, 1'b1, 1'b0);
        chk("pout", 8'ha5);
        chk("poe", 8'h00);
        u_gpio.oe_n <= 1'b0;
        chk("poe", 8'hff);
    endtask : sc_byte
    task automatic sc_both;
        u_gpio.pulse(1'b1, 1'b1, 1'b0);
        chk("pout", 8'ha5);
        u_gpio.pulse(1'b0, 1'b1, 1'b0);
        chk("pout", 8'h4a);
        u_gpio.clr_n <= 1'b0;
        u_gpio.pulse(1'b0, 1'b1, 1'b0);
        chk("pout", 8'h4a);
    endtask : sc_both
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        sc_init();
        sc_byte();
        sc_both();
        tally_and_finish();
    end
endmodule : tb_sipo_latch
